// ---- rtl/async_serial_channel_defs.svh ----
`ifndef ASYNC_SERIAL_CHANNEL_DEFS_SVH
`define ASYNC_SERIAL_CHANNEL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_PRIMARY_STATUS 4'h0
`define OFF_SECONDARY_STATUS 4'h1
`define OFF_RX_CONTROL 4'h3
`define OFF_MODE_CONFIG 4'h4
`define OFF_TX_CONTROL 4'h5
`define OFF_SYNC_PATTERN_LOW 4'h6
`define OFF_SYNC_PATTERN_HIGH 4'h7
`define OFF_TX_BUFFER 4'h8
`define OFF_EXTENDED_FEATURE 4'h9
`define OFF_ENCODING_CONTROL 4'ha
`define OFF_FEATURE_ENABLE 4'hf

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MC_PARITY_EN 0
`define MC_PARITY_EVEN 1
`define MC_STOP_LO 2
`define MC_MODE_LO 4
`define MC_FACTOR_LO 6
`define TC_RTS 1
`define TC_TX_EN 3
`define TC_BREAK 4
`define TC_LEN_LO 5
`define RC_RX_EN 0
`define RC_AUTO_EN 5
`define RC_LEN_LO 6
`define PS_RX_AVAIL 0
`define PS_TX_EMPTY 2
`define PS_CTS 5
`define PS_BREAK 7
`define SS_ALL_SENT 0
`define SS_PARITY_ERR 4
`define SS_FRAME_ERR 6
`define FE_AUTO_RTS 0
`define XF_AUTO_RTS 2

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define STOP_SYNC 2'h0
`define STOP_ONE 2'h1
`define STOP_ONE_HALF 2'h2
`define MODE_FRAME 2'h2
`define ENC_AUTO_RTS 2'h2
`define RST_REG 8'h00

`endif

// ---- rtl/async_serial_channel_pkg.sv ----
package async_serial_channel_pkg;

	// Receiver sequencing
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_STOP = 3'b011,
		RX_EXTEND = 3'b100
	} rx_state_t;

	// Transmitter sequencing
	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_t;

endpackage

// ---- rtl/async_serial_channel_core.sv ----
`timescale 1ns/10ps
`include "async_serial_channel_defs.svh"

// How it works
// - parity enable appends one bit per character
// - sense bit one means even, zero odd
// - break drives zeros between bit-cell edges
// - break forces line low even when disabled
// - rts pin inverts bit, cts in status
// - auto enables gate transmitter with cts pin
// - async auto holds rts until all sent
// - frame mode auto rts held until empty
// - start edge confirmed low after half bit
// - start stop stripped, parity kept if short
// - stop sampled; low sets framing error flag
// - framing flag travels with its character
// - framing error adds half bit delay
// - long characters pass three-stage delay first
// - null plus framing error sets break status
// - break end stores one null character
// - clock factor 1/16/32/64 shared both ways
// - unity factor waits one clock; sync forced
// - async frames shift register, no sync/crc
// - idle line high; write fills buffer, then shifter
// - all-sent sets at final stop bit
// - stop field 1, 2, 2 full cells for transmit
// - five to eight bits, lsb first
// - parity mismatch flagged with character
module async_serial_channel_core #(
	parameter int CHAN_DIV = 1 // Core cycles per channel clock tick
) (
	input wire logic core_clk, // 10 MHz core clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [3:0] reg_addr, // Register offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic rxd, // Serial receive pin
	input wire logic cts_n, // Clear-to-send pin, active low
	output logic txd, // Serial transmit pin
	output logic rts_n // Request-to-send pin, active low
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Character length code to bit count, same code both ways
	function automatic logic [3:0] char_len(input logic [1:0] code);
		unique case (code)
			2'h0: char_len = 4'h5;
			2'h1: char_len = 4'h7;
			2'h2: char_len = 4'h6;
			default: char_len = 4'h8;
		endcase
	endfunction

	// Bits to send; five-bit code also carries shorter formats
	function automatic logic [3:0] tx_bits(input logic [1:0] code, input logic [7:0] d);
		tx_bits = char_len(code);
		if (code == 2'h0) begin
			if (d[7:4] == 4'hf) begin
				tx_bits = 4'h1;
			end else if (d[7:5] == 3'h7) begin
				tx_bits = 4'h2;
			end else if (d[7:6] == 2'h3) begin
				tx_bits = 4'h3;
			end else if (d[7]) begin
				tx_bits = 4'h4;
			end
		end
	endfunction

	// Mask that keeps the low n bits
	function automatic logic [7:0] low_mask(input logic [3:0] n);
		low_mask = 8'hff >> (4'h8 - n);
	endfunction

	// Start bit, data, optional parity, then ones for stop
	function automatic logic [11:0] build_frame(input logic [7:0] d, input logic [3:0] n,
			input logic pen, input logic par);
		build_frame = 12'hfff;
		build_frame[0] = 1'b0;
		for (int j = 0; j < 8; j++) begin
			if (4'(j) < n) begin
				build_frame[j + 1] = d[j];
			end else if (4'(j) == n && pen) begin
				build_frame[j + 1] = par;
			end
		end
		if (n == 4'h8 && pen) begin
			build_frame[9] = par;
		end
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam logic [15:0] DIV_LAST = 16'(CHAN_DIV - 1); // Divider wrap value

	logic [15:0] chan_cnt_ff; // Channel clock divider
	logic [7:0] mode_ff, txc_ff, rxc_ff; // Mode, transmit and receive control
	logic [7:0] feat_ff, xfeat_ff, enc_ff; // Feature, extended, encoding control
	logic [7:0] sync_lo_ff, sync_hi_ff; // Sync patterns, kept for readback only
	logic [7:0] rdata_ff; // Read data register
	logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff; // Receive pin synchroniser and history
	logic cts_s1_ff, cts_s2_ff; // Clear-to-send synchroniser
	async_serial_channel_pkg::tx_state_t tx_state_ff; // Transmitter state
	logic [6:0] tx_cnt_ff; // Ticks within the bit cell
	logic [11:0] tx_sr_ff; // Transmit shift register
	logic [3:0] tx_cells_ff; // Cells still to send after the current one
	logic [7:0] tx_buf_ff; // Transmit buffer
	logic tx_full_ff; // Buffer holds a character
	logic tx_half_ff; // One and a half stops requested; no cell is shortened
	logic brk_ff; // Break active on the line
	logic txd_ff, rts_n_ff; // Pin registers
	logic all_sent_ff; // Transmitter completely empty
	async_serial_channel_pkg::rx_state_t rx_state_ff; // Receiver state
	logic [6:0] rx_cnt_ff; // Ticks to the next sample
	logic [3:0] rx_idx_ff; // Bits assembled so far
	logic [8:0] rx_sr_ff; // Receive shift register
	logic [2:0] rx_dly_ff; // Three-stage delay for long characters
	logic rx_par_ff; // Running parity of received bits
	logic [7:0] rx_char_ff; // Received character holding register
	logic rx_fe_ff, rx_pe_ff, rx_avail_ff; // Flags stored with the character
	logic rx_brk_ff; // Break seen on the line

	// ----------------------------------------
	// Decoding and selection
	// ----------------------------------------
	wire chan_tick = (chan_cnt_ff >= DIV_LAST); // One-cycle channel clock enable
	wire wr_buf = reg_wr && reg_addr == `OFF_TX_BUFFER;
	wire rd_char = reg_rd && reg_addr == `OFF_TX_BUFFER; // Same offset reads received data
	wire [1:0] stop_sel = mode_ff[`MC_STOP_LO +: 2];
	wire is_async = stop_sel != `STOP_SYNC;
	wire frame_mode = !is_async && mode_ff[`MC_MODE_LO +: 2] == `MODE_FRAME;
	wire par_en = mode_ff[`MC_PARITY_EN];
	wire par_even = mode_ff[`MC_PARITY_EVEN];
	wire [1:0] fsel = is_async ? mode_ff[`MC_FACTOR_LO +: 2] : 2'h0;
	wire [6:0] bit_len = (fsel == 2'h0) ? 7'd1 : (7'd8 << fsel);
	wire [6:0] half_len = (bit_len == 7'd1) ? 7'd1 : (bit_len >> 1);
	wire cts_low = !cts_s2_ff;
	wire tx_go = txc_ff[`TC_TX_EN] && (!rxc_ff[`RC_AUTO_EN] || cts_low);
	wire tx_empty = tx_state_ff == async_serial_channel_pkg::TX_IDLE && !tx_full_ff;
	wire tx_done = tx_state_ff == async_serial_channel_pkg::TX_IDLE || tx_cells_ff == 4'h0;
	wire last_half = tx_half_ff && tx_cells_ff == 4'h0 && !tx_done;
	wire [6:0] cell_len = (tx_state_ff == async_serial_channel_pkg::TX_SHIFT && last_half) ? half_len : bit_len;
	wire bit_edge = chan_tick && tx_cnt_ff >= cell_len - 7'd1; // Bit-cell boundary
	wire [3:0] tx_n = tx_bits(txc_ff[`TC_LEN_LO +: 2], tx_buf_ff);
	wire tx_par = ^(tx_buf_ff & low_mask(tx_n)) ^ !par_even;
	wire [11:0] tx_frame = build_frame(tx_buf_ff, tx_n, par_en, tx_par);
	// One and a half stops become two full cells at every factor
	wire [3:0] stop_cells = (stop_sel == `STOP_ONE || stop_sel == `STOP_SYNC) ? 4'h1 : 4'h2;
	wire [3:0] tx_total = tx_n + {3'h0, par_en} + stop_cells; // Cells after the start bit
	wire rts_auto = (is_async && rxc_ff[`RC_AUTO_EN]) || (frame_mode && feat_ff[`FE_AUTO_RTS]
		&& xfeat_ff[`XF_AUTO_RTS] && enc_ff[3:2] == `ENC_AUTO_RTS);
	wire rx_en = rxc_ff[`RC_RX_EN];
	wire [3:0] rx_len = char_len(rxc_ff[`RC_LEN_LO +: 2]);
	wire [3:0] rx_n = rx_len + {3'h0, par_en}; // Bits assembled per character
	wire rx_long = rx_len >= 4'h7;
	wire rx_fall = !rxd_s2_ff && rxd_s3_ff; // High-to-low on the line
	wire rx_expire = chan_tick && rx_cnt_ff <= 7'd1;
	wire rx_bit = rxd_s2_ff;
	wire [11:0] rx_asm = rx_long ? {rx_dly_ff, rx_sr_ff} : {3'h0, rx_sr_ff};
	wire [3:0] rx_sh = (rx_long ? 4'hc : 4'h9) - rx_n;
	wire [11:0] rx_just = rx_asm >> rx_sh; // Right-justified, parity above data
	wire [7:0] rx_word = rx_just[7:0];
	wire rx_null = (rx_word & low_mask(rx_len)) == 8'h00;
	wire rx_fe = !rx_bit;
	wire rx_pe = par_en && (rx_par_ff ^ !par_even);
	wire rx_store = rx_state_ff == async_serial_channel_pkg::RX_STOP && rx_expire;
	wire brk_end = rx_brk_ff && rx_bit && rx_state_ff == async_serial_channel_pkg::RX_IDLE;
	wire [7:0] prim_status = {rx_brk_ff, 1'b0, cts_low, 2'b00, !tx_full_ff, 1'b0, rx_avail_ff};
	wire [7:0] sec_status = {1'b0, rx_fe_ff, 1'b0, rx_pe_ff, 3'h0, all_sent_ff};
	logic [7:0] rd_mux; // Selected read value
	always_comb begin
		unique case (reg_addr)
			`OFF_PRIMARY_STATUS: rd_mux = prim_status;
			`OFF_SECONDARY_STATUS: rd_mux = sec_status;
			`OFF_RX_CONTROL: rd_mux = rxc_ff;
			`OFF_MODE_CONFIG: rd_mux = mode_ff;
			`OFF_TX_CONTROL: rd_mux = txc_ff;
			`OFF_SYNC_PATTERN_LOW: rd_mux = sync_lo_ff;
			`OFF_SYNC_PATTERN_HIGH: rd_mux = sync_hi_ff;
			`OFF_TX_BUFFER: rd_mux = rx_char_ff;
			`OFF_EXTENDED_FEATURE: rd_mux = xfeat_ff;
			`OFF_ENCODING_CONTROL: rd_mux = enc_ff;
			`OFF_FEATURE_ENABLE: rd_mux = feat_ff;
			default: rd_mux = 8'h00; // Unmapped offsets read zero
		endcase
	end

	assign reg_rdata = rdata_ff;
	assign txd = txd_ff;
	assign rts_n = rts_n_ff;

	// ----------------------------------------
	// Channel clock divider and pin synchronisers
	// ----------------------------------------

	// Divider gives the channel clock as an enable pulse
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_cnt_ff <= 16'h0000;
		end else begin
			chan_cnt_ff <= chan_tick ? 16'h0000 : chan_cnt_ff + 16'h0001;
		end
	end

	// Two flops per pin; the third only remembers the line for edges
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{rxd_s1_ff, rxd_s2_ff, rxd_s3_ff} <= 3'h7;
			{cts_s1_ff, cts_s2_ff} <= 2'h3;
		end else begin
			{rxd_s3_ff, rxd_s2_ff, rxd_s1_ff} <= {rxd_s2_ff, rxd_s1_ff, rxd};
			{cts_s2_ff, cts_s1_ff} <= {cts_s1_ff, cts_n};
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------

	// Configuration writes; reset leaves both directions off
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{mode_ff, txc_ff, rxc_ff, feat_ff} <= {4{`RST_REG}};
			{xfeat_ff, enc_ff, sync_lo_ff, sync_hi_ff} <= {4{`RST_REG}};
		end else if (reg_wr) begin
			unique case (reg_addr)
				`OFF_MODE_CONFIG: mode_ff <= reg_wdata;
				`OFF_TX_CONTROL: txc_ff <= reg_wdata;
				`OFF_RX_CONTROL: rxc_ff <= reg_wdata;
				`OFF_FEATURE_ENABLE: feat_ff <= reg_wdata;
				`OFF_EXTENDED_FEATURE: xfeat_ff <= reg_wdata;
				`OFF_ENCODING_CONTROL: enc_ff <= reg_wdata;
				`OFF_SYNC_PATTERN_LOW: sync_lo_ff <= reg_wdata;
				`OFF_SYNC_PATTERN_HIGH: sync_hi_ff <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------

	// Buffer: a write fills it, a load into the shifter wins nothing over it
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_buf_ff <= 8'h00;
			tx_full_ff <= 1'b0;
		end else if (wr_buf) begin
			tx_buf_ff <= reg_wdata;
			tx_full_ff <= 1'b1;
		end else if (bit_edge && !brk_ff && !txc_ff[`TC_BREAK] && tx_done && tx_go) begin
			tx_full_ff <= 1'b0;
		end
	end

	// Bit-cell timer runs always, so break timing holds when idle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_cnt_ff <= 7'd0;
		end else if (chan_tick) begin
			tx_cnt_ff <= bit_edge ? 7'd0 : tx_cnt_ff + 7'd1;
		end
	end

	// Shifter, break and line; everything moves on bit-cell edges
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_ff <= async_serial_channel_pkg::TX_IDLE;
			tx_sr_ff <= 12'hfff;
			tx_cells_ff <= 4'h0;
			tx_half_ff <= 1'b0;
			brk_ff <= 1'b0;
			txd_ff <= 1'b1;
		end else if (bit_edge) begin
			brk_ff <= txc_ff[`TC_BREAK];
			if (txc_ff[`TC_BREAK]) begin
				txd_ff <= 1'b0;
			end else if (!tx_done) begin
				// Resumes the held shifter after a break
				txd_ff <= tx_sr_ff[0];
				tx_sr_ff <= {1'b1, tx_sr_ff[11:1]};
				tx_cells_ff <= tx_cells_ff - 4'h1;
			end else if (tx_full_ff && tx_go && !brk_ff) begin // One marking cell after a break, as the buffer expects
				// Start bit goes out now, the rest shifts straight to the pin
				txd_ff <= 1'b0;
				tx_sr_ff <= {1'b1, tx_frame[11:1]};
				tx_cells_ff <= tx_total;
				tx_half_ff <= stop_sel == `STOP_ONE_HALF && bit_len != 7'd1;
				tx_state_ff <= async_serial_channel_pkg::TX_SHIFT;
			end else begin
				txd_ff <= 1'b1;
				tx_state_ff <= async_serial_channel_pkg::TX_IDLE;
			end
		end
	end

	// All sent rises as the last stop cell starts with nothing waiting
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			all_sent_ff <= 1'b1;
		end else if (bit_edge && !txc_ff[`TC_BREAK] && !tx_done && tx_cells_ff == 4'h1 && !tx_full_ff) begin
			all_sent_ff <= 1'b1;
		end else if (wr_buf) begin
			all_sent_ff <= 1'b0;
		end
	end

	// Auto modes keep the pin active until the shifter is empty
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rts_n_ff <= 1'b1;
		end else begin
			rts_n_ff <= !(txc_ff[`TC_RTS] || (rts_auto && !(tx_empty && all_sent_ff)));
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------

	// Start detection, assembly and stop check
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_ff <= async_serial_channel_pkg::RX_IDLE;
			rx_cnt_ff <= 7'd0;
			rx_idx_ff <= 4'h0;
			rx_sr_ff <= 9'h000;
			rx_dly_ff <= 3'h0;
			rx_par_ff <= 1'b0;
		end else begin
			if (chan_tick && rx_cnt_ff != 7'd0) begin
				rx_cnt_ff <= rx_cnt_ff - 7'd1;
			end
			unique case (rx_state_ff)
				async_serial_channel_pkg::RX_IDLE: begin
					if (rx_en && rx_fall) begin
						rx_state_ff <= async_serial_channel_pkg::RX_START;
						rx_cnt_ff <= half_len;
						rx_idx_ff <= 4'h0;
						rx_sr_ff <= 9'h000;
						rx_dly_ff <= 3'h0;
						rx_par_ff <= 1'b0;
					end
				end
				async_serial_channel_pkg::RX_START: begin
					if (rx_expire) begin
						// A glitch that is high again is not a start bit
						rx_state_ff <= rx_bit ? async_serial_channel_pkg::RX_IDLE : async_serial_channel_pkg::RX_DATA;
						rx_cnt_ff <= bit_len;
					end
				end
				async_serial_channel_pkg::RX_DATA: begin
					if (rx_expire) begin
						rx_par_ff <= rx_par_ff ^ rx_bit;
						if (rx_long) begin
							rx_dly_ff <= {rx_bit, rx_dly_ff[2:1]};
							rx_sr_ff <= {rx_dly_ff[0], rx_sr_ff[8:1]};
						end else begin
							rx_sr_ff <= {rx_bit, rx_sr_ff[8:1]};
						end
						rx_idx_ff <= rx_idx_ff + 4'h1;
						rx_cnt_ff <= bit_len;
						if (rx_idx_ff == rx_n - 4'h1) begin
							rx_state_ff <= async_serial_channel_pkg::RX_STOP;
						end
					end
				end
				async_serial_channel_pkg::RX_STOP: begin
					if (rx_expire) begin
						// Half bit more so a low stop is not a new start
						rx_state_ff <= rx_fe ? async_serial_channel_pkg::RX_EXTEND : async_serial_channel_pkg::RX_IDLE;
						rx_cnt_ff <= half_len;
					end
				end
				async_serial_channel_pkg::RX_EXTEND: begin
					if (rx_expire) begin
						rx_state_ff <= async_serial_channel_pkg::RX_IDLE;
					end
				end
				default: rx_state_ff <= async_serial_channel_pkg::RX_IDLE;
			endcase
		end
	end

	// Holding register; flags are stored with the character, not latched
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_char_ff <= 8'h00;
			rx_fe_ff <= 1'b0;
			rx_pe_ff <= 1'b0;
			rx_avail_ff <= 1'b0;
		end else if (rx_store) begin
			rx_char_ff <= rx_word;
			rx_fe_ff <= rx_fe;
			rx_pe_ff <= rx_pe;
			rx_avail_ff <= 1'b1; // Set wins over a read in the same cycle
		end else if (brk_end) begin
			rx_char_ff <= 8'h00;
			rx_fe_ff <= 1'b0;
			rx_pe_ff <= par_en && !par_even;
			rx_avail_ff <= 1'b1;
		end else if (rd_char) begin
			rx_avail_ff <= 1'b0;
		end
	end

	// Break status holds until the line returns to one
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_brk_ff <= 1'b0;
		end else if (rx_store && rx_fe && rx_null) begin
			rx_brk_ff <= 1'b1;
		end else if (brk_end) begin
			rx_brk_ff <= 1'b0;
		end
	end

endmodule

// ---- verification/async_serial_channel_props.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Port-level checks of the serial channel
// ----------------------------------------
module async_serial_channel_props #(
	parameter int CHAN_DIV = 1 // Core cycles per channel tick
) (
	input wire logic core_clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic [3:0] reg_addr, // Offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic rxd, // Serial in
	input wire logic cts_n, // Clear-to-send, active low
	input wire logic txd, // Serial out
	input wire logic rts_n // Request-to-send, active low
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic brk_on_ff; // Last written break bit
	logic [5:0] brk_cnt_ff; // Cycles since break was set, saturating
	logic [7:0] sync_ff; // Last value written to the low sync pattern
	wire tc_wr = reg_wr && reg_addr == 4'h5; // Transmit control write
	// Track break request age; the 40-cycle limit holds for x16 and CHAN_DIV up to 2
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			brk_on_ff <= 1'b0;
			brk_cnt_ff <= 6'h00;
			sync_ff <= 8'h00;
		end else begin
			if (tc_wr) begin
				brk_on_ff <= reg_wdata[4];
				brk_cnt_ff <= 6'h00;
			end else if (brk_on_ff && brk_cnt_ff != 6'h3f) begin
				brk_cnt_ff <= brk_cnt_ff + 6'h01;
			end
			if (reg_wr && reg_addr == 4'h6) begin
				sync_ff <= reg_wdata;
			end
		end
	end
	AST_RESET_MARK: assert property ($rose(reset_n) |-> txd && rts_n && reg_rdata == 8'h00)
		else $error("line not idle after reset");
	AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_SYNC_READBACK: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata == sync_ff)
		else $error("sync pattern readback wrong");
	AST_RTS_BIT: assert property (tc_wr && reg_wdata[1] |-> ##[1:3] !rts_n)
		else $error("rts pin not low after rts bit set");
	AST_CTS_STATUS: assert property (reg_rd && reg_addr == 4'h0 && $stable(cts_n) && cts_n == $past(cts_n, 4)
		|=> reg_rdata[5] == !$past(cts_n))
		else $error("cts status bit wrong");
	AST_BREAK_START: assert property (tc_wr && reg_wdata[4] |-> ##[1:40] !txd)
		else $error("break not started");
	AST_BREAK_HOLD: assert property (brk_on_ff && brk_cnt_ff >= 6'h28 |-> !txd)
		else $error("line high during break");
endmodule

bind async_serial_channel_core async_serial_channel_props #(.CHAN_DIV(CHAN_DIV)) u_async_serial_channel_props (
	.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));

// ---- verification/async_serial_terminal_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Remote terminal: frames on rxd, samples txd
// ----------------------------------------
module async_serial_terminal_model #(
	parameter int BIT_CYC = 16 // Core cycles per bit
) (
	input wire logic core_clk, // Clock
	input wire logic txd, // Line from the channel
	output logic rxd // Line into the channel, marking when idle
);
	initial rxd = 1'b1;
	// Start, eight data LSB first, parity, stop; a low stop forces a framing error
	task automatic send(input logic [7:0] d, input logic par, input logic stp);
		logic [10:0] frm;
		frm = {stp, par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= frm[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask
	// Spacing line for a number of bit times, then marking again
	task automatic hold_low(input int bits);
		rxd <= 1'b0;
		repeat (bits * BIT_CYC) @(posedge core_clk);
		rxd <= 1'b1;
	endtask
	// Sample mid-cell on the falling clock so the result never races the line update
	task automatic recv(output logic [9:0] frm);
		int n;
		frm = 'x;
		n = 0;
		while (txd !== 1'b0 && n < 800) begin
			@(negedge core_clk);
			n++;
		end
		if (n < 800) begin
			repeat (BIT_CYC / 2) @(negedge core_clk);
			for (int i = 0; i < 10; i++) begin
				repeat (BIT_CYC) @(negedge core_clk);
				frm[i] = txd;
			end
		end
	endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	logic core_clk = 1'b0; // 10 MHz clock
	logic reset_n = 1'b0; // Reset, active low
	logic [3:0] reg_addr = 4'h0; // Offset
	logic [7:0] reg_wdata = 8'h00; // Write data
	logic reg_wr = 1'b0; // Write strobe
	logic reg_rd = 1'b0; // Read strobe
	logic cts_n = 1'b0; // Clear-to-send, active low
	logic [7:0] reg_rdata; // Read data
	logic rxd; // Line from the terminal
	logic txd; // Line to the terminal
	logic rts_n; // Request-to-send pin
	int fails = 0; // Mismatches
	int checks = 0; // Comparisons
	int cycles = 0; // Elapsed clock cycles
	logic [7:0] rx_d [3] = '{8'h5a, 8'h5a, 8'hc3}; // Received data
	logic rx_p [3] = '{1'b0, 1'b1, 1'b0}; // Parity bit sent
	logic rx_s [3] = '{1'b1, 1'b1, 1'b0}; // Stop bit sent
	logic [7:0] rx_st [3] = '{8'h01, 8'h11, 8'h41}; // Expected secondary status

	always #50 core_clk = ~core_clk;

	async_serial_channel_core #(.CHAN_DIV(1)) u_async_serial_channel_core (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
	async_serial_terminal_model #(.BIT_CYC(16)) u_async_serial_terminal_model (
		.core_clk(core_clk), .txd(txd), .rxd(rxd));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Answer stands only in the cycle after the strobe, so it is taken mid-cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, exp)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic stop_test();
		$display("fails=%0d checks=%0d", fails, checks);
		if (fails == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs a few thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [9:0] frm;
		logic [7:0] d;
		logic stuck;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		// Pin status needs two synchroniser cycles to settle
		idle(2);
		chk_rd(4'h0, 8'h24);
		chk_rd(4'h1, 8'h01);
		chk_rd(4'h5, 8'h00);
		chk_rd(4'h2, 8'h00);
		`CHK(txd, 1'b1)
		// Break with the transmitter still disabled
		wr(4'h5, 8'h10);
		idle(40);
		`CHK(txd, 1'b0)
		wr(4'h5, 8'h00);
		idle(40);
		`CHK(txd, 1'b1)
		wr(4'h6, 8'h96);
		chk_rd(4'h6, 8'h96);
		// Mode first, then receive and transmit control with their enables
		wr(4'h4, 8'h47);
		wr(4'h3, 8'hc1);
		wr(4'h5, 8'h6a);
		idle(3);
		`CHK(rts_n, 1'b0)
		wr(4'h5, 8'h68);
		// Even then odd parity on characters of even and odd weight
		for (int e = 1; e >= 0; e--) begin
			d = e ? 8'ha5 : 8'h3d;
			wr(4'h4, {6'h11, e[0], 1'b1});
			fork
				wr(4'h8, d);
				u_async_serial_terminal_model.recv(frm);
			join
			`CHK(frm, {1'b1, (^d) ^ !e[0], d})
			idle(16);
			chk_rd(4'h1, 8'h01);
		end
		// Good, bad parity, and framing error characters
		wr(4'h4, 8'h47);
		for (int k = 0; k < 3; k++) begin
			u_async_serial_terminal_model.send(rx_d[k], rx_p[k], rx_s[k]);
			idle(24);
			chk_rd(4'h1, rx_st[k]);
			chk_rd(4'h8, rx_d[k]);
		end
		// Line break seen by the receiver, odd parity
		wr(4'h4, 8'h45);
		fork
			u_async_serial_terminal_model.hold_low(20);
			begin
				idle(250);
				rd(4'h0, d);
			end
		join
		`CHK(d[7], 1'b1)
		idle(40);
		chk_rd(4'h1, 8'h11);
		chk_rd(4'h8, 8'h00);
		rd(4'h0, d);
		`CHK(d[7], 1'b0)
		// Auto enables: clear-to-send gates the pending character
		@(posedge core_clk) cts_n <= 1'b1;
		wr(4'h3, 8'he1);
		wr(4'h8, 8'h81);
		stuck = 1'b0;
		repeat (100) @(negedge core_clk) if (txd !== 1'b1) stuck = 1'b1;
		`CHK(stuck, 1'b0)
		chk_rd(4'h0, 8'h00);
		`CHK(rts_n, 1'b0)
		fork
			@(posedge core_clk) cts_n <= 1'b0;
			u_async_serial_terminal_model.recv(frm);
		join
		`CHK(frm, {1'b1, 1'b1, 8'h81})
		idle(20);
		`CHK(rts_n, 1'b1)
		// Frame submode with every auto request-to-send bit set
		wr(4'h4, 8'h20);
		wr(4'hf, 8'h01);
		wr(4'h9, 8'h04);
		wr(4'ha, 8'h08);
		wr(4'h8, 8'h55);
		idle(2);
		`CHK(rts_n, 1'b0)
		idle(20);
		`CHK(rts_n, 1'b1)
		stop_test();
	end
endmodule
